// ### opt_pkg.sv
// shared constants and types for the one-shot / pwm timer channel
package opt_pkg;
  // register bus shape
  localparam int OPT_AW = 4;
  localparam int OPT_DW = 16;
  // register offsets
  localparam logic [3:0] OPT_CTRL_OFS = 4'h0;
  localparam logic [3:0] OPT_COUNT_OFS = 4'h1;
  localparam logic [3:0] OPT_IRQ_OFS = 4'h2;
  localparam logic [3:0] OPT_STAT_OFS = 4'h3;
  // control register fields
  localparam int OPT_START_POS = 0;
  localparam int OPT_OS_START_POS = 1;
  localparam int OPT_MODE_POS = 2;
  localparam int OPT_PWM8_POS = 4;
  localparam int OPT_CKSEL_POS = 5;
  localparam int OPT_POUT_EN_POS = 7;
  localparam int OPT_TRIG_EN_POS = 8;
  localparam int OPT_OVF_EN_POS = 9;
  localparam int OPT_GP_OUT_POS = 10;
  // one-shot start is a write-only pulse, never stored
  localparam logic [15:0] OPT_CTRL_MASK = 16'h07FD;
  localparam logic [15:0] OPT_CTRL_RST = 16'h0000;
  localparam logic [15:0] OPT_COUNT_RST = 16'h0000;
  // status register fields
  localparam int OPT_ST_RUN_POS = 0;
  localparam int OPT_ST_OUT_POS = 1;
  localparam int OPT_ST_TRIG_POS = 2;
  // operation mode codes
  localparam logic [1:0] OPT_MODE_TIMER = 2'h0;
  localparam logic [1:0] OPT_MODE_EVENT = 2'h1;
  localparam logic [1:0] OPT_MODE_ONESHOT = 2'h2;
  localparam logic [1:0] OPT_MODE_PWM = 2'h3;
  // count clock selections
  localparam logic [1:0] OPT_CK_DIV1 = 2'h0;
  localparam logic [1:0] OPT_CK_DIV8 = 2'h1;
  localparam logic [1:0] OPT_CK_DIV32 = 2'h2;
  localparam logic [1:0] OPT_CK_SUB32 = 2'h3;
  // pwm cycle lengths in count units
  localparam logic [15:0] OPT_PWM16_PERIOD = 16'hFFFF;
  localparam logic [15:0] OPT_PWM8_PERIOD = 16'h00FF;
  typedef enum logic [1:0] {OPT_IDLE, OPT_ONESHOT_RUN, OPT_PWM_RUN} opt_state_e;
endpackage

// ### opt_prescale.sv
// count clock prescaler: undivided, /8, /32 and subclock /32
`timescale 1ns/1ps
module opt_prescale (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [1:0] sel_in, // count clock selection
  input wire logic subclock_tick_in, // one pulse per subclock period
  output logic tick_out // one-cycle count clock tick
);
  import opt_pkg::*;

  logic [4:0] div_ff;
  logic [4:0] sub_ff;
  logic tick_ff;
  logic nxt_tick;

  // free-running dividers; the outputs are phase-unaligned to any start
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_ff <= 5'h00;
      sub_ff <= 5'h00;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 5'h01;
      if (subclock_tick_in) begin
        sub_ff <= sub_ff + 5'h01;
      end
      tick_ff <= nxt_tick;
    end
  end

  // selected_count_clock tick pick
  always_comb begin
    case (sel_in)
      OPT_CK_DIV1: nxt_tick = 1'b1;
      OPT_CK_DIV8: nxt_tick = (div_ff[2:0] == 3'h7);
      OPT_CK_DIV32: nxt_tick = (div_ff == 5'h1F);
      OPT_CK_SUB32: nxt_tick = subclock_tick_in && (sub_ff == 5'h1F);
      default: nxt_tick = 1'b0;
    endcase
  end

  assign tick_out = tick_ff;
endmodule

// ### opt_timer.sv
// one-shot and pwm down-counting timer channel with register port
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module opt_timer (
  input wire logic clk_in, // 50 MHz system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [opt_pkg::OPT_AW-1:0] addr_in, // register index
  input wire logic [opt_pkg::OPT_DW-1:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [opt_pkg::OPT_DW-1:0] rdata_out, // read data, cycle after strobe
  input wire logic timer_trigger_input_pin_in, // trigger / general input pin
  input wire logic timer_overflow_in, // overflow pulse of the selected timer
  input wire logic subclock_tick_in, // subclock tick for the slow source
  output logic timer_pulse_output_pin_out, // pulse / general output pin
  output logic irq_out // channel interrupt request bit
);
  import opt_pkg::*;

  logic [15:0] ctrl_ff, reload_ff, count_ff, period_ff, rdata_ff;
  logic [15:0] nxt_count, nxt_period, nxt_reload, rd_mux;
  logic [7:0] pre_ff, nxt_pre;
  logic irq_ff, out_ff, pin_ff, trig_d_ff;
  logic nxt_out, set_irq, nxt_irq, nxt_pin;
  opt_state_e state_ff, nxt_state;
  logic tick;

  // count clock source
  opt_prescale u_prescale (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sel_in(ctrl_ff[OPT_CKSEL_POS+:2]),
    .subclock_tick_in(subclock_tick_in),
    .tick_out(tick)
  );

  // register decode
  wire wr_ctrl = wr_in && (addr_in == OPT_CTRL_OFS);
  wire wr_cnt = wr_in && (addr_in == OPT_COUNT_OFS);
  wire wr_irq = wr_in && (addr_in == OPT_IRQ_OFS);
  wire [1:0] mode = ctrl_ff[OPT_MODE_POS+:2];
  wire [1:0] new_mode = wdata_in[OPT_MODE_POS+:2];
  wire start_flag = ctrl_ff[OPT_START_POS];
  wire pwm8 = ctrl_ff[OPT_PWM8_POS];
  wire trig_en = ctrl_ff[OPT_TRIG_EN_POS];
  wire ovf_en = ctrl_ff[OPT_OVF_EN_POS];
  wire running = (state_ff != OPT_IDLE);

  // mode entry from timer or event counter mode raises a request
  wire old_plain = (mode == OPT_MODE_TIMER) || (mode == OPT_MODE_EVENT);
  wire mode_irq = wr_ctrl && old_plain &&
                  ((new_mode == OPT_MODE_ONESHOT) || (new_mode == OPT_MODE_PWM));

  // stop requests: start flag cleared, or mode left under a run
  wire start_clear = wr_ctrl && start_flag && !wdata_in[OPT_START_POS];
  wire leave_mode = wr_ctrl && (new_mode != mode);
  wire stop_req = start_clear || leave_mode;

  // start causes: trigger rising edge, timer overflow, software flag
  wire trig_edge = trig_en && timer_trigger_input_pin_in && !trig_d_ff;
  wire ext_start = trig_edge || (ovf_en && timer_overflow_in);
  wire os_start = (mode == OPT_MODE_ONESHOT) && start_flag && !stop_req &&
                  (ext_start || (wr_ctrl && wdata_in[OPT_OS_START_POS]));
  // with no external cause enabled, the start flag alone runs pwm
  wire pwm_start = (mode == OPT_MODE_PWM) && start_flag && !stop_req &&
                   (ext_start || (!trig_en && !ovf_en));

  // pwm geometry: 8-bit mode scales units by m+1 via pre_ff
  wire pwm_unit = tick && (!pwm8 || (pre_ff == 8'h00));
  wire [15:0] pwm_width = pwm8 ? {8'h00, reload_ff[15:8]} : reload_ff;
  wire [15:0] pwm_period = pwm8 ? OPT_PWM8_PERIOD : OPT_PWM16_PERIOD;

  // reload register: any counter write lands here
  assign nxt_reload = wr_cnt ? wdata_in : reload_ff;

  // main sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_period = period_ff;
    nxt_pre = pre_ff;
    nxt_out = out_ff;
    set_irq = mode_irq;
    case (state_ff)
      OPT_IDLE: begin
        if (wr_cnt) begin
          nxt_count = wdata_in;
        end
        if (os_start) begin
          nxt_state = OPT_ONESHOT_RUN;
          nxt_out = 1'b1;
        end else if (pwm_start) begin
          nxt_state = OPT_PWM_RUN;
          nxt_count = pwm_width;
          nxt_period = pwm_period;
          nxt_pre = reload_ff[7:0];
          nxt_out = (pwm_width != 16'h0000);
        end
      end
      OPT_ONESHOT_RUN: begin
        if (stop_req) begin
          nxt_state = OPT_IDLE;
          nxt_count = reload_ff;
          nxt_out = 1'b0;
          set_irq = set_irq || start_clear;
        end else if (os_start) begin
          nxt_count = reload_ff;
        end else if (tick) begin
          if (count_ff <= 16'h0001) begin
            nxt_state = OPT_IDLE;
            nxt_count = reload_ff;
            nxt_out = 1'b0;
            set_irq = 1'b1;
          end else begin
            nxt_count = count_ff - 16'h0001;
          end
        end
      end
      OPT_PWM_RUN: begin
        // triggers are not looked at here at all
        if (stop_req) begin
          nxt_state = OPT_IDLE;
          nxt_out = 1'b0;
          set_irq = set_irq || (start_clear && out_ff);
        end else begin
          if (tick && pwm8) begin
            nxt_pre = (pre_ff == 8'h00) ? reload_ff[7:0] : pre_ff - 8'h01;
          end
          if (pwm_unit) begin
            if (period_ff <= 16'h0001) begin
              nxt_period = pwm_period;
              nxt_count = pwm_width;
              nxt_out = (pwm_width != 16'h0000);
            end else begin
              nxt_period = period_ff - 16'h0001;
              if (count_ff != 16'h0000) begin
                nxt_count = count_ff - 16'h0001;
              end
              if (count_ff == 16'h0001) begin
                nxt_out = 1'b0;
                set_irq = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        nxt_state = OPT_IDLE;
        nxt_out = 1'b0;
      end
    endcase
  end

  // request bit: hardware set wins over a software clear (write 0)
  assign nxt_irq = set_irq || (irq_ff && !(wr_irq && !wdata_in[0]));

  // pin: pwm forces the pulse; otherwise enable picks pulse or port latch
  assign nxt_pin = ((nxt_state == OPT_PWM_RUN) || ctrl_ff[OPT_POUT_EN_POS]) ?
                   nxt_out : ctrl_ff[OPT_GP_OUT_POS];

  // read mux; the counter offset shows the reload value, never the live count
  always_comb begin
    case (addr_in)
      OPT_CTRL_OFS: rd_mux = ctrl_ff;
      OPT_COUNT_OFS: rd_mux = reload_ff;
      OPT_IRQ_OFS: rd_mux = {15'h0000, irq_ff};
      OPT_STAT_OFS: rd_mux = {13'h0000, timer_trigger_input_pin_in, out_ff, running};
      default: rd_mux = 16'h0000;
    endcase
  end

  // control and data registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ff <= OPT_CTRL_RST;
      reload_ff <= OPT_COUNT_RST;
      trig_d_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata_in & OPT_CTRL_MASK;
      end
      reload_ff <= nxt_reload;
      trig_d_ff <= timer_trigger_input_pin_in;
      rdata_ff <= rd_in ? rd_mux : 16'h0000;
    end
  end

  // counting state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= OPT_IDLE;
      count_ff <= OPT_COUNT_RST;
      period_ff <= 16'h0000;
      pre_ff <= 8'h00;
      out_ff <= 1'b0;
      irq_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      period_ff <= nxt_period;
      pre_ff <= nxt_pre;
      out_ff <= nxt_out;
      irq_ff <= nxt_irq;
      pin_ff <= nxt_pin;
    end
  end

  assign rdata_out = rdata_ff;
  assign timer_pulse_output_pin_out = pin_ff;
  assign irq_out = irq_ff;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence os_clear_s;
    (state_ff == OPT_ONESHOT_RUN) && start_clear;
  endsequence

  sequence os_last_tick_s;
    (state_ff == OPT_ONESHOT_RUN) && !stop_req && !os_start && tick && (count_ff == 16'h0001);
  endsequence

  sequence pwm_fall_s;
    (state_ff == OPT_PWM_RUN) && !stop_req && pwm_unit && out_ff &&
    (count_ff == 16'h0001) && (period_ff > 16'h0001);
  endsequence

  oneshot_stop_a: assert property (os_clear_s |=>
    (state_ff == OPT_IDLE) && !out_ff && irq_ff && (count_ff == $past(reload_ff)))
    else $error("one-shot stop did not reload, drop and request");

  mode_entry_irq_a: assert property (mode_irq |=> irq_ff)
    else $error("mode entry did not set the request");

  oneshot_end_a: assert property (os_last_tick_s |=>
    (state_ff == OPT_IDLE) && !out_ff && irq_ff && (count_ff == $past(reload_ff)))
    else $error("one-shot end did not halt with request");

  oneshot_retrig_a: assert property ((state_ff == OPT_ONESHOT_RUN) && os_start |=>
    (state_ff == OPT_ONESHOT_RUN) && (count_ff == $past(reload_ff)))
    else $error("retrigger did not reload counter");

  oneshot_start_a: assert property ((state_ff == OPT_IDLE) && os_start |=>
    (state_ff == OPT_ONESHOT_RUN) && out_ff ##0 (out_ff [*1]))
    else $error("one-shot start did not raise the pulse");

  stopped_write_a: assert property ((state_ff == OPT_IDLE) && wr_cnt && !pwm_start |=>
    (count_ff == $past(wdata_in)) && (reload_ff == $past(wdata_in)))
    else $error("stopped write did not load both");

  running_write_a: assert property ((state_ff == OPT_ONESHOT_RUN) && wr_cnt && !stop_req && !os_start &&
    (count_ff > 16'h0001) |=> (reload_ff == $past(wdata_in)) &&
    (count_ff == $past(count_ff) - {15'h0000, $past(tick)}))
    else $error("running write disturbed the counter");

  pwm_stop_a: assert property ((state_ff == OPT_PWM_RUN) && start_clear |=>
    !out_ff && (irq_ff == ($past(out_ff) || $past(irq_ff) || $past(mode_irq))))
    else $error("pwm stop request handling wrong");

  pwm_fall_irq_a: assert property (pwm_fall_s |=> !out_ff && irq_ff)
    else $error("pwm falling edge without request");

  pwm_no_trig_a: assert property ((state_ff == OPT_PWM_RUN) && ext_start && !stop_req && !pwm_unit |=>
    (state_ff == OPT_PWM_RUN) && $stable(count_ff) && $stable(period_ff))
    else $error("trigger disturbed running pwm");

  pwm_pin_a: assert property ((state_ff == OPT_PWM_RUN) |-> (pin_ff == out_ff))
    else $error("pwm pin not the pulse");

  irq_read_a: assert property (rd_in && (addr_in == OPT_IRQ_OFS) |=>
    (rdata_out == {15'h0000, $past(irq_ff)}) ##1 (rdata_out == 16'h0000) or
    (rdata_out == {15'h0000, $past(irq_ff)}) ##1 $past(rd_in))
    else $error("request read data wrong");

  // further guards on counting, pins and the request bit
  oneshot_zero_irq_a: assert property ((state_ff == OPT_ONESHOT_RUN) && !stop_req && !os_start && tick &&
    (count_ff <= 16'h0001) |=> irq_ff && (state_ff == OPT_IDLE))
    else $error("one-shot zero without request");

  oneshot_high_a: assert property ((state_ff == OPT_ONESHOT_RUN) |-> out_ff)
    else $error("one-shot pulse low while running");

  idle_hold_a: assert property ((state_ff == OPT_IDLE) && !wr_cnt && !pwm_start |=> $stable(count_ff))
    else $error("halted counter moved");

  oneshot_trig_a: assert property ((state_ff == OPT_IDLE) && (mode == OPT_MODE_ONESHOT) && start_flag &&
    trig_edge && !stop_req |=> (state_ff == OPT_ONESHOT_RUN))
    else $error("trigger did not start one-shot");

  pwm_ovf_start_a: assert property ((state_ff == OPT_IDLE) && (mode == OPT_MODE_PWM) && start_flag &&
    ovf_en && timer_overflow_in && !stop_req |=> (state_ff == OPT_PWM_RUN))
    else $error("overflow did not start pwm");

  pwm_hold_a: assert property ((state_ff == OPT_PWM_RUN) && !stop_req |=> (state_ff == OPT_PWM_RUN))
    else $error("pwm stopped without flag clear");

  pwm_width16_a: assert property ((state_ff == OPT_IDLE) && pwm_start && !pwm8 |=>
    (count_ff == $past(reload_ff)) && (period_ff == OPT_PWM16_PERIOD))
    else $error("16-bit pwm start geometry wrong");

  pwm_width8_a: assert property ((state_ff == OPT_IDLE) && pwm_start && pwm8 |=>
    (count_ff == {8'h00, $past(reload_ff[15:8])}) && (period_ff == OPT_PWM8_PERIOD) &&
    (pre_ff == $past(reload_ff[7:0])))
    else $error("8-bit pwm start geometry wrong");

  pwm_reload_a: assert property ((state_ff == OPT_PWM_RUN) && !stop_req && pwm_unit &&
    (period_ff <= 16'h0001) |=> (count_ff == $past(pwm_width)) && (out_ff == ($past(pwm_width) != 16'h0000)))
    else $error("pwm cycle start did not reload");

  pwm8_prescale_a: assert property ((state_ff == OPT_PWM_RUN) && pwm8 && tick && !stop_req &&
    (pre_ff != 8'h00) |=> (pre_ff == $past(pre_ff) - 8'h01) && $stable(count_ff))
    else $error("8-bit unit prescale wrong");

  pwm_low_stop_a: assert property ((state_ff == OPT_PWM_RUN) && start_clear && !out_ff |=>
    !out_ff && (irq_ff == $past(irq_ff)))
    else $error("pwm stop while low raised a request");

  gport_pin_a: assert property ((state_ff == OPT_IDLE) && !ctrl_ff[OPT_POUT_EN_POS] && !pwm_start |=>
    (pin_ff == $past(ctrl_ff[OPT_GP_OUT_POS])))
    else $error("general port level not on the pin");

  count_read_a: assert property (rd_in && (addr_in == OPT_COUNT_OFS) |=> (rdata_out == $past(reload_ff)))
    else $error("counter read not the reload value");

  irq_clear_a: assert property (wr_irq && !wdata_in[0] && !set_irq |=> !irq_ff)
    else $error("request clear did not take");
endmodule

// ### opt_partner.sv
// partner model: trigger source, overflow source, subclock and pulse load
`timescale 1ns/1ps
module opt_partner (
  input wire logic clk_in, // system clock
  input wire logic pin_in, // pulse output load, observed only
  output logic trig_out, // trigger pin drive
  output logic ovf_out, // overflow pulse of the selected timer
  output logic sub_tick_out // subclock tick, one per 16 cycles
);
  logic [3:0] sub_ff;
  logic pin_d_ff = 1'b0;
  int rise_cnt_ff = 0;
  // quiet lines from time zero
  initial begin
    trig_out = 1'b0;
    ovf_out = 1'b0;
    sub_tick_out = 1'b0;
    sub_ff = 4'h0;
  end
  // free-running slow source, unrelated to any start
  always @(posedge clk_in) begin
    sub_ff <= sub_ff + 4'h1;
    sub_tick_out <= (sub_ff == 4'hF);
  end
  // the load counts pulse starts, so a stray or missing pulse shows up
  always @(posedge clk_in) begin
    pin_d_ff <= pin_in;
    if (pin_in && !pin_d_ff) begin
      rise_cnt_ff <= rise_cnt_ff + 1;
    end
  end
  // trigger held a few cycles so a slow edge detector still sees it
  task automatic fire_trig();
    @(posedge clk_in);
    trig_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    trig_out <= 1'b0;
  endtask
  // single-cycle overflow pulse
  task automatic fire_ovf();
    @(posedge clk_in);
    ovf_out <= 1'b1;
    @(posedge clk_in);
    ovf_out <= 1'b0;
  endtask
endmodule

// ### opt_timer_bench.sv
// self-checking bench for the one-shot / pwm timer channel
`timescale 1ns/1ps
module opt_timer_bench;
  import opt_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [OPT_AW-1:0] addr_in = '0;
  logic [OPT_DW-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [OPT_DW-1:0] rdata_out;
  logic trig, ovf, sub_tick, pin, irq_out;
  logic [OPT_DW-1:0] d;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int h, l;
  // 50 MHz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  opt_timer dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .timer_trigger_input_pin_in(trig),
    .timer_overflow_in(ovf), .subclock_tick_in(sub_tick), .timer_pulse_output_pin_out(pin), .irq_out(irq_out));
  opt_partner peer (.clk_in(clk_in), .pin_in(pin), .trig_out(trig), .ovf_out(ovf), .sub_tick_out(sub_tick));
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    // sample mid-cycle, clear of the edge that drops the data
    @(negedge clk_in);
    v = rdata_out;
  endtask
  // counts cycles until the pin shows v, bounded
  task automatic wait_pin(input logic v, output int n);
    n = 0;
    while (pin !== v && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 2000) chk(1'b0, "pin wait ran out");
  endtask
  task automatic t_reset();
    chk(irq_out === 1'b0 && pin === 1'b0, "reset outputs");
    rd(OPT_CTRL_OFS, d);
    chk(d === OPT_CTRL_RST, "ctrl reset value");
    rd(4'hF, d);
    chk(d === 16'h0000, "unmapped read");
  endtask
  task automatic t_gport();
    wr(OPT_CTRL_OFS, 16'h0400);
    repeat (2) @(posedge clk_in);
    chk(pin === 1'b1, "general port level");
    wr(OPT_CTRL_OFS, 16'h0000);
  endtask
  task automatic t_oneshot();
    wr(OPT_CTRL_OFS, 16'h0089);
    repeat (2) @(posedge clk_in);
    chk(irq_out === 1'b1, "request on one-shot entry");
    wr(OPT_IRQ_OFS, 16'h0000);
    repeat (2) @(posedge clk_in);
    chk(irq_out === 1'b0, "request clear");
    wr(OPT_COUNT_OFS, 16'h0005);
    for (int i = 0; i < 2; i++) begin
      wr(OPT_CTRL_OFS, 16'h008B);
      wait_pin(1'b1, l);
      wait_pin(1'b0, h);
      chk(h == 5, "one-shot high time");
      chk(irq_out === 1'b1, "request at zero");
      rd(OPT_IRQ_OFS, d);
      chk(d === 16'h0001, "request bit read");
      wr(OPT_IRQ_OFS, 16'h0000);
      rd(OPT_STAT_OFS, d);
      chk(d[OPT_ST_RUN_POS] === 1'b0, "halt after zero");
    end
  endtask
  task automatic t_retrig();
    wr(OPT_COUNT_OFS, 16'h0014);
    wr(OPT_CTRL_OFS, 16'h0189);
    peer.fire_trig();
    wait_pin(1'b1, l);
    repeat (10) @(posedge clk_in);
    peer.fire_trig();
    wait_pin(1'b0, h);
    chk(h >= 17 && h <= 24, "retrigger restarts count");
  endtask
  task automatic t_runwrite();
    wr(OPT_COUNT_OFS, 16'h000A);
    wr(OPT_CTRL_OFS, 16'h008B);
    wait_pin(1'b1, l);
    wr(OPT_COUNT_OFS, 16'h0004);
    wait_pin(1'b0, h);
    chk(h >= 6 && h <= 9, "running write leaves counter");
    wr(OPT_CTRL_OFS, 16'h008B);
    wait_pin(1'b1, l);
    wait_pin(1'b0, h);
    chk(h == 4, "reload takes new value");
  endtask
  task automatic t_stop_os();
    wr(OPT_COUNT_OFS, 16'h0028);
    wr(OPT_CTRL_OFS, 16'h008B);
    wait_pin(1'b1, l);
    wr(OPT_IRQ_OFS, 16'h0000);
    wr(OPT_CTRL_OFS, 16'h0088);
    repeat (2) @(posedge clk_in);
    chk(pin === 1'b0 && irq_out === 1'b1, "one-shot stop");
    wr(OPT_CTRL_OFS, 16'h0089);
    wr(OPT_CTRL_OFS, 16'h008B);
    wait_pin(1'b1, l);
    wait_pin(1'b0, h);
    chk(h == 40, "stop reloads counter");
    rd(OPT_COUNT_OFS, d);
    chk(d === 16'h0028, "counter read shows reload");
  endtask
  task automatic t_clksel();
    int dv[3] = '{8, 32, 512};
    wr(OPT_COUNT_OFS, 16'h0002);
    for (int s = 1; s < 4; s++) begin
      wr(OPT_CTRL_OFS, 16'h0089 | 16'(s << OPT_CKSEL_POS));
      wr(OPT_CTRL_OFS, 16'h008B | 16'(s << OPT_CKSEL_POS));
      wait_pin(1'b1, l);
      wait_pin(1'b0, h);
      chk(h > dv[s-1] && h <= 2 * dv[s-1] + 1, "prescaled high time");
    end
  endtask
  task automatic t_pwm8();
    wr(OPT_CTRL_OFS, 16'h0000);
    wr(OPT_COUNT_OFS, 16'h0301);
    wr(OPT_CTRL_OFS, 16'h011D);
    repeat (2) @(posedge clk_in);
    chk(irq_out === 1'b1, "request on pwm entry");
    wr(OPT_IRQ_OFS, 16'h0000);
    peer.fire_trig();
    wait_pin(1'b1, l);
    wait_pin(1'b0, h);
    chk(irq_out === 1'b1, "request on falling edge");
    fork
      peer.fire_trig();
      wait_pin(1'b1, l);
    join
    wait_pin(1'b0, h);
    chk(h == 6 && h + l == 510, "8-bit width and cycle");
    wr(OPT_IRQ_OFS, 16'h0000);
    wait_pin(1'b1, l);
    wr(OPT_CTRL_OFS, 16'h011C);
    repeat (2) @(posedge clk_in);
    chk(pin === 1'b0 && irq_out === 1'b1, "pwm stop while high");
  endtask
  task automatic t_pwm_ovf();
    wr(OPT_IRQ_OFS, 16'h0000);
    wr(OPT_CTRL_OFS, 16'h021D);
    repeat (20) @(posedge clk_in);
    chk(pin === 1'b0, "no start before overflow");
    peer.fire_ovf();
    wait_pin(1'b1, l);
    chk(l < 20, "overflow starts pwm");
    wait_pin(1'b0, h);
    wr(OPT_IRQ_OFS, 16'h0000);
    wr(OPT_CTRL_OFS, 16'h021C);
    repeat (2) @(posedge clk_in);
    chk(pin === 1'b0 && irq_out === 1'b0, "pwm stop while low");
  endtask
  task automatic t_pwm16();
    int r0;
    wr(OPT_COUNT_OFS, 16'h0003);
    r0 = peer.rise_cnt_ff;
    wr(OPT_CTRL_OFS, 16'h000D);
    wait_pin(1'b1, l);
    wait_pin(1'b0, h);
    chk(h == 3, "16-bit high time");
    chk(peer.rise_cnt_ff == r0 + 1, "one pulse at the load");
    wr(OPT_CTRL_OFS, 16'h000C);
  endtask
  // hang guard, well above the sum of all scenarios
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end
  // reset, then scenarios in turn
  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_gport();
    t_oneshot();
    t_retrig();
    t_runwrite();
    t_stop_os();
    t_clksel();
    t_pwm8();
    t_pwm_ovf();
    t_pwm16();
    end_sim();
  end
endmodule
